// file: src_controller.sv
// Reset controller: supply filtering, reset sequencing, reset pin and registers
`timescale 1ns/1ps
module src_controller #(
   parameter int         STARTUP_CYCLES = src_pkg::STARTUP_DEFAULT,
   parameter logic [7:0] WRITE_KEY      = 8'h5a  // Arbitrary value
) (
   input  wire logic        clock,
   input  wire logic        rstn,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata,
   input  wire logic        backup_supply,
   input  wire logic        core_supply,
   input  wire logic        reset_pin_in,
   output logic             reset_pin_out,
   output logic             reset_pin_oe,
   input  wire logic        boot_select_pin,
   input  wire logic        watchdog_fault,
   input  wire logic        watchdog_proc_only,
   output logic             proc_nreset,
   output logic             backup_nreset,
   output logic             periph_nreset,
   output logic             ext_nreset,
   output logic             proc_clk_en,
   output logic             boot_select,
   output logic             user_irq
);

   // ---------------------------------------------------------------
   // Input synchronisation
   // ---------------------------------------------------------------
   logic [3:0] sync_q;
   logic       backup_ok;
   logic       core_ok;
   logic       pin_level;
   logic       boot_level;

   src_sync #(
      .WIDTH   (4),
      .RST_VAL (4'h4)
   ) u_sync (
      .clock    (clock),
      .rstn     (rstn),
      .async_in ({boot_select_pin, reset_pin_in, core_supply, backup_supply}),
      .sync_out (sync_q)
   );

   assign backup_ok  = sync_q[0];
   assign core_ok    = sync_q[1];
   assign pin_level  = sync_q[2];
   assign boot_level = sync_q[3];

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic                         user_reset_enable;
   logic                         user_reset_irq_enable;
   logic [src_pkg::LEN_W-1:0]    ext_reset_length;
   logic                         user_reset_status;
   logic [src_pkg::TYPE_W-1:0]   reset_type;
   logic [src_pkg::TYPE_W-1:0]   pending_type;
   logic                         pin_prev;
   logic                         key_ok;
   logic                         ctrl_wr;
   logic                         mode_wr;
   logic                         status_rd;

   assign key_ok    = wdata[src_pkg::KEY_LSB +: src_pkg::KEY_W] == WRITE_KEY;
   assign ctrl_wr   = wr && addr == src_pkg::CTRL_OFFSET && key_ok;
   assign mode_wr   = wr && addr == src_pkg::MODE_OFFSET && key_ok;
   assign status_rd = rd && addr == src_pkg::STATUS_OFFSET;

   // Mode register lives with the backup supply
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         user_reset_enable     <= src_pkg::UEN_RESET;
         user_reset_irq_enable <= src_pkg::IEN_RESET;
         ext_reset_length      <= src_pkg::LEN_RESET;
      end else if (!backup_ok) begin
         user_reset_enable     <= src_pkg::UEN_RESET;
         user_reset_irq_enable <= src_pkg::IEN_RESET;
         ext_reset_length      <= src_pkg::LEN_RESET;
      end else if (mode_wr) begin
         user_reset_enable     <= wdata[src_pkg::MODE_UEN_BIT];
         user_reset_irq_enable <= wdata[src_pkg::MODE_IEN_BIT];
         ext_reset_length      <= wdata[src_pkg::MODE_LEN_LSB +: src_pkg::LEN_W];
      end
   end

   // User reset flag: falling pin edge sets, status read clears, set wins
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pin_prev          <= 1'b1;
         user_reset_status <= 1'b0;
      end else begin
         pin_prev <= pin_level;
         if (pin_prev && !pin_level) begin
            user_reset_status <= 1'b1;
         end else if (status_rd) begin
            user_reset_status <= 1'b0;
         end
      end
   end

   // Interrupt only when the pin does not reset the part
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         user_irq <= 1'b0;
      end else begin
         user_irq <= user_reset_status && user_reset_irq_enable
                     && !user_reset_enable;
      end
   end

   // ---------------------------------------------------------------
   // State manager
   // ---------------------------------------------------------------
   src_pkg::src_state_t        state;
   src_pkg::src_state_t        next_state;
   logic [src_pkg::CNT_W-1:0]  cnt;
   logic [src_pkg::CNT_W-1:0]  next_cnt;
   logic                       soft_proc;
   logic                       soft_periph;
   logic                       wdog_proc_only;
   logic                       soft_go;
   logic                       ext_start;
   logic                       pin_masked;
   logic                       user_go;
   logic [src_pkg::CNT_W-1:0]  startup_len;
   logic [src_pkg::CNT_W-1:0]  hold_len;

   assign startup_len = src_pkg::CNT_W'(STARTUP_CYCLES - 1);
   assign hold_len    = src_pkg::CNT_W'(src_pkg::HOLD_CYCLES - 1);
   assign soft_go     = ctrl_wr && state == src_pkg::SRC_RUN
                        && (wdata[src_pkg::CTRL_PROC_BIT]
                           || wdata[src_pkg::CTRL_PERIPH_BIT]
                           || wdata[src_pkg::CTRL_EXT_BIT]);
   assign user_go     = !pin_level && user_reset_enable && !pin_masked;

   always_comb begin
      next_state = state;
      next_cnt   = (cnt != '0) ? cnt - 1'b1 : cnt;
      if (!backup_ok) begin
         next_state = src_pkg::SRC_BACKUP_OFF;
         next_cnt   = startup_len;
      end else begin
         case (state)
            src_pkg::SRC_BACKUP_OFF: begin
               next_state = src_pkg::SRC_STARTUP;
               next_cnt   = startup_len;
            end
            src_pkg::SRC_STARTUP: begin
               if (cnt == '0) begin
                  next_state = src_pkg::SRC_CLK_ON;
                  next_cnt   = hold_len;
               end
            end
            src_pkg::SRC_CLK_ON: begin
               if (cnt == '0) begin
                  next_state = src_pkg::SRC_RUN;
               end
            end
            default: begin
               // Core supply is only watched once the backup reset is gone
               if (!core_ok) begin
                  next_state = src_pkg::SRC_CORE_OFF;
               end else if (state == src_pkg::SRC_CORE_OFF) begin
                  next_state = src_pkg::SRC_WAKE;
                  next_cnt   = hold_len;
               end else if (watchdog_fault
                            && state inside {src_pkg::SRC_RUN, src_pkg::SRC_SOFT}) begin
                  next_state = src_pkg::SRC_WDOG;
                  next_cnt   = hold_len;
               end else begin
                  case (state)
                     src_pkg::SRC_RUN: begin
                        if (soft_go) begin
                           next_state = src_pkg::SRC_SOFT;
                           next_cnt   = hold_len;
                        end else if (user_go) begin
                           next_state = src_pkg::SRC_USER;
                        end
                     end
                     src_pkg::SRC_USER: begin
                        if (pin_level) begin
                           next_state = src_pkg::SRC_USER_EXIT;
                           next_cnt   = hold_len;
                        end
                     end
                     src_pkg::SRC_WAKE, src_pkg::SRC_USER_EXIT, src_pkg::SRC_SOFT,
                     src_pkg::SRC_WDOG: begin
                        if (cnt == '0) begin
                           next_state = src_pkg::SRC_RUN;
                        end
                     end
                     default: begin
                        next_state = src_pkg::SRC_RUN;
                     end
                  endcase
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state <= src_pkg::SRC_BACKUP_OFF;
         cnt   <= '0;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
      end
   end

   // Latched flavour of software and watchdog resets, plus pending type
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         soft_proc      <= 1'b0;
         soft_periph    <= 1'b0;
         wdog_proc_only <= 1'b0;
         pending_type   <= src_pkg::TYPE_GENERAL;
      end else begin
         if (next_state != state) begin
            case (next_state)
               src_pkg::SRC_BACKUP_OFF: pending_type <= src_pkg::TYPE_GENERAL;
               src_pkg::SRC_CORE_OFF:   pending_type <= src_pkg::TYPE_WAKEUP;
               src_pkg::SRC_WDOG:       pending_type <= src_pkg::TYPE_WATCHDOG;
               src_pkg::SRC_USER:       pending_type <= src_pkg::TYPE_USER;
               src_pkg::SRC_SOFT: begin
                  if (wdata[src_pkg::CTRL_PROC_BIT]) begin
                     pending_type <= src_pkg::TYPE_SOFTWARE;
                  end
               end
               default: pending_type <= pending_type;
            endcase
         end
         if (soft_go) begin
            soft_proc   <= wdata[src_pkg::CTRL_PROC_BIT];
            soft_periph <= wdata[src_pkg::CTRL_PERIPH_BIT];
         end
         if (next_state == src_pkg::SRC_WDOG && state != src_pkg::SRC_WDOG) begin
            wdog_proc_only <= watchdog_proc_only;
         end
      end
   end

   // ---------------------------------------------------------------
   // Reset outputs
   // ---------------------------------------------------------------
   logic next_proc;
   logic next_periph;
   logic next_backup;
   logic next_clk;
   logic next_hold;

   always_comb begin
      next_backup = !(next_state inside {src_pkg::SRC_BACKUP_OFF, src_pkg::SRC_STARTUP,
                                         src_pkg::SRC_CLK_ON});
      next_hold   = next_state inside {src_pkg::SRC_BACKUP_OFF, src_pkg::SRC_STARTUP,
                                       src_pkg::SRC_CLK_ON, src_pkg::SRC_CORE_OFF,
                                       src_pkg::SRC_WAKE};
      next_clk    = !(next_state inside {src_pkg::SRC_BACKUP_OFF, src_pkg::SRC_STARTUP,
                                         src_pkg::SRC_CORE_OFF, src_pkg::SRC_USER});
      case (next_state)
         src_pkg::SRC_RUN: begin
            next_proc   = 1'b1;
            next_periph = 1'b1;
         end
         src_pkg::SRC_SOFT: begin
            next_proc   = !soft_proc;
            next_periph = !soft_periph;
            if (state != src_pkg::SRC_SOFT) begin
               next_proc   = !wdata[src_pkg::CTRL_PROC_BIT];
               next_periph = !wdata[src_pkg::CTRL_PERIPH_BIT];
            end
         end
         src_pkg::SRC_WDOG: begin
            next_proc   = 1'b0;
            next_periph = (state == src_pkg::SRC_WDOG) ? wdog_proc_only : watchdog_proc_only;
         end
         default: begin
            next_proc   = 1'b0;
            next_periph = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         proc_nreset   <= 1'b0;
         periph_nreset <= 1'b0;
         backup_nreset <= 1'b0;
         proc_clk_en   <= 1'b0;
         reset_type    <= src_pkg::TYPE_GENERAL;
      end else begin
         proc_nreset   <= next_proc;
         periph_nreset <= next_periph;
         backup_nreset <= next_backup;
         proc_clk_en   <= next_clk;
         if (!proc_nreset && next_proc) begin
            reset_type <= pending_type;
         end
      end
   end

   // ---------------------------------------------------------------
   // Reset pin driver
   // ---------------------------------------------------------------
   logic [src_pkg::CNT_W-1:0] ext_cnt;
   logic [src_pkg::CNT_W-1:0] next_ext_cnt;
   logic [src_pkg::CNT_W-1:0] ext_len;
   logic [2:0]                mask_cnt;
   logic                      pin_drive;

   // Shift amount widened so the longest length does not wrap to zero
   assign ext_len   = src_pkg::CNT_W'(1) << ({1'b0, ext_reset_length} + 5'h1);
   assign ext_start = (soft_go && wdata[src_pkg::CTRL_EXT_BIT])
                      || (next_state == src_pkg::SRC_USER && state != src_pkg::SRC_USER)
                      || (next_state == src_pkg::SRC_WDOG && state != src_pkg::SRC_WDOG
                          && !watchdog_proc_only);
   assign pin_masked = pin_drive || mask_cnt != '0;

   always_comb begin
      if (next_hold) begin
         next_ext_cnt = ext_len;
      end else if (ext_start) begin
         next_ext_cnt = ext_len - 1'b1;
      end else if (ext_cnt != '0) begin
         next_ext_cnt = ext_cnt - 1'b1;
      end else begin
         next_ext_cnt = '0;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ext_cnt   <= '0;
         pin_drive <= 1'b1;
         mask_cnt  <= '0;
      end else begin
         ext_cnt   <= next_ext_cnt;
         pin_drive <= next_hold || ext_start || ext_cnt != '0;
         // Own pulse must not start a user reset; it still sets the status flag
         if (pin_drive) begin
            mask_cnt <= 3'(src_pkg::PIN_MASK_CYCLES);
         end else if (mask_cnt != '0) begin
            mask_cnt <= mask_cnt - 1'b1;
         end
      end
   end

   assign reset_pin_out = 1'b0;
   assign reset_pin_oe  = pin_drive;
   assign ext_nreset    = !pin_drive;

   // ---------------------------------------------------------------
   // Boot select capture
   // ---------------------------------------------------------------
   logic       core_prev;
   logic [1:0] boot_cnt;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         core_prev   <= 1'b0;
         boot_cnt    <= '0;
         boot_select <= 1'b0;
      end else begin
         core_prev <= core_ok;
         if (core_ok && !core_prev) begin
            boot_cnt <= 2'(src_pkg::BOOT_CYCLES - 1);
         end else if (boot_cnt != '0) begin
            boot_cnt <= boot_cnt - 1'b1;
            if (boot_cnt == 2'h1) begin
               boot_select <= boot_level;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Read port
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rdata <= '0;
      end else if (rd) begin
         rdata <= '0;
         case (addr)
            src_pkg::STATUS_OFFSET: begin
               rdata[src_pkg::ST_USTAT_BIT] <= user_reset_status;
               rdata[src_pkg::ST_TYPE_LSB +: src_pkg::TYPE_W] <= reset_type;
               rdata[src_pkg::ST_LEVEL_BIT] <= pin_level;
               rdata[src_pkg::ST_BUSY_BIT]  <= state == src_pkg::SRC_SOFT;
            end
            src_pkg::MODE_OFFSET: begin
               rdata[src_pkg::MODE_UEN_BIT] <= user_reset_enable;
               rdata[src_pkg::MODE_IEN_BIT] <= user_reset_irq_enable;
               rdata[src_pkg::MODE_LEN_LSB +: src_pkg::LEN_W] <= ext_reset_length;
            end
            default: rdata <= '0;
         endcase
      end else begin
         rdata <= '0;
      end
   end

endmodule : src_controller

// file: src_controller_chk.sv
// Checker: timing relations between the reset controller's ports
`timescale 1ns/1ps
module src_controller_chk (
   input wire logic clock,
   input wire logic rstn,
   input wire logic backup_supply,
   input wire logic reset_pin_out,
   input wire logic reset_pin_oe,
   input wire logic proc_nreset,
   input wire logic backup_nreset,
   input wire logic periph_nreset,
   input wire logic ext_nreset,
   input wire logic proc_clk_en
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   a_pin_never_high: assert property (reset_pin_out == 1'b0)
      else $error("reset pin driven high");
   a_ext_follows_oe: assert property (ext_nreset == !reset_pin_oe)
      else $error("ext reset disagrees with pin drive");
   a_backup_loss_all: assert property ((!backup_supply)[*6] |->
      !backup_nreset && !proc_nreset && !periph_nreset && reset_pin_oe)
      else $error("reset missing while backup supply low");
   a_clock_before_rel: assert property ($rose(proc_nreset) |->
      proc_clk_en && $past(proc_clk_en) && $past(proc_clk_en, 2)
      && $past(proc_clk_en, 3))
      else $error("processor released without three clocked cycles");
   a_backup_first: assert property (!backup_nreset |-> !proc_nreset)
      else $error("processor released while backup in reset");
   a_pulse_min_two: assert property ($rose(reset_pin_oe) |-> reset_pin_oe[*2])
      else $error("pin pulse shorter than two cycles");
   a_release_together: assert property ($rose(backup_nreset) |->
      proc_nreset && periph_nreset)
      else $error("general reset released unevenly");
   a_pin_after_backup: assert property ($rose(backup_nreset) |->
      reset_pin_oe ##1 reset_pin_oe ##1 !reset_pin_oe)
      else $error("pin not released two cycles after backup reset");
endmodule : src_controller_chk

bind src_controller src_controller_chk src_controller_chk_i (.clock(clock), .rstn(rstn),
   .backup_supply(backup_supply), .reset_pin_out(reset_pin_out),
   .reset_pin_oe(reset_pin_oe), .proc_nreset(proc_nreset), .backup_nreset(backup_nreset),
   .periph_nreset(periph_nreset), .ext_nreset(ext_nreset), .proc_clk_en(proc_clk_en));

// file: src_controller_tb.sv
// Testbench: self-checking sequences for the reset controller
`timescale 1ns/1ps
module system_reset_controller_tb;
   logic clock = 0, rstn = 0, wr = 0, rd = 0, bkp = 1, core = 1, boot = 1;
   logic wdf = 0, pull = 0, pin, oe, pout, prn, brn, pern, ern, cen, bsel, irq;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, v;
   logic [31:0] row_w [4] = '{32'h5a000001, 32'h5a000311, 32'h11000f00, 32'h5a000100};
   logic [31:0] row_r [4] = '{32'h00000001, 32'h00000311, 32'h00000311, 32'h00000100};
   int n_fail = 0, cmp_count = 0, n;
   src_controller #(.STARTUP_CYCLES(4)) src_controller_i (.clock(clock), .rstn(rstn),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .backup_supply(bkp),
      .core_supply(core), .reset_pin_in(pin), .reset_pin_out(pout), .reset_pin_oe(oe),
      .boot_select_pin(boot), .watchdog_fault(wdf), .watchdog_proc_only(1'b0),
      .proc_nreset(prn), .backup_nreset(brn), .periph_nreset(pern), .ext_nreset(ern),
      .proc_clk_en(cen), .boot_select(bsel), .user_irq(irq));
   src_pin_partner src_pin_partner_i (.ctrl_oe(oe), .ext_pull(pull), .pin_level(pin));
   initial forever #4 clock = ~clock;
   task chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         n_fail++;
         $display("unexpected at %0t: seen %h wanted %h", $time, s, e);
      end
   endtask : chk
   task wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      wr <= 1'b1; addr <= a; wdata <= d;
      @(posedge clock);
      wr <= 1'b0;
   endtask : wr_reg
   task rd_reg(input logic [7:0] a);
      @(posedge clock);
      rd <= 1'b1; addr <= a;
      @(posedge clock);
      rd <= 1'b0;
      #1 v = rdata;
   endtask : rd_reg
   task cycles(input int c);
      repeat (c) @(posedge clock);
      #1;
   endtask : cycles
   // Wait for the processor reset to end, bounded
   task wait_rel;
      cycles(3);
      for (int i = 0; i < 2000 && prn !== 1'b1; i++) cycles(1);
      chk(prn, 1'b1);
      cycles(12);
   endtask : wait_rel
   task complete_run;
      $display("counts: %0d compares, %0d mismatches", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : complete_run
   initial begin
      #300000 n_fail++;
      complete_run();
   end
   initial begin
      cycles(5);
      chk({prn, brn, pern, oe}, 4'h1);
      rstn <= 1'b1;
      wait_rel();
      chk({prn, brn, pern, cen, bsel}, 5'h1f);
      rd_reg(src_pkg::STATUS_OFFSET);
      chk(v[18:8], 11'h100);
      rd_reg(8'h0c);
      chk(v, 32'h0);
      $display("reset test done");
      for (int i = 0; i < 4; i++) begin
         wr_reg(src_pkg::MODE_OFFSET, row_w[i]);
         rd_reg(src_pkg::MODE_OFFSET);
         chk(v, row_r[i]);
      end
      $display("mode table done");
      for (int l = 0; l < 3; l++) begin
         wr_reg(src_pkg::MODE_OFFSET, 32'h5a000001 | (l << 8));
         wr_reg(src_pkg::CTRL_OFFSET, 32'h5a000008);
         n = 0;
         // Pulse starts at the write edge, so look before the next edge
         #1;
         repeat (40) begin
            if (oe === 1'b1) n++;
            cycles(1);
         end
         chk(n, 2 << l);
         chk(prn, 1'b1);
      end
      $display("pin pulse test done");
      pull <= 1'b1;
      cycles(10);
      chk({prn, pern, brn}, 3'h1);
      pull <= 1'b0;
      wait_rel();
      rd_reg(src_pkg::STATUS_OFFSET);
      chk({v[10:8], v[0]}, {src_pkg::TYPE_USER, 1'b1});
      rd_reg(src_pkg::STATUS_OFFSET);
      chk(v[0], 1'b0);
      $display("user reset test done");
      wr_reg(src_pkg::MODE_OFFSET, 32'h5a000010);
      pull <= 1'b1;
      cycles(10);
      chk({prn, irq}, 2'h3);
      rd_reg(src_pkg::STATUS_OFFSET);
      chk({v[16], v[0]}, 2'h1);
      pull <= 1'b0;
      cycles(4);
      chk(irq, 1'b0);
      $display("user interrupt test done");
      wr_reg(src_pkg::CTRL_OFFSET, 32'h5a000005);
      wait_rel();
      rd_reg(src_pkg::STATUS_OFFSET);
      chk(v[10:8], src_pkg::TYPE_SOFTWARE);
      @(posedge clock);
      wdf <= 1'b1;
      @(posedge clock);
      wdf <= 1'b0;
      wait_rel();
      rd_reg(src_pkg::STATUS_OFFSET);
      chk(v[10:8], src_pkg::TYPE_WATCHDOG);
      $display("soft and watchdog test done");
      core <= 1'b0;
      cycles(10);
      chk({prn, pern, brn}, 3'h1);
      core <= 1'b1;
      wait_rel();
      rd_reg(src_pkg::STATUS_OFFSET);
      chk(v[10:8], src_pkg::TYPE_WAKEUP);
      rd_reg(src_pkg::MODE_OFFSET);
      chk(v, 32'h00000010);
      $display("wake-up test done");
      bkp <= 1'b0;
      cycles(10);
      chk({prn, pern, brn, oe}, 4'h1);
      bkp <= 1'b1;
      wait_rel();
      rd_reg(src_pkg::STATUS_OFFSET);
      chk(v[10:8], src_pkg::TYPE_GENERAL);
      rd_reg(src_pkg::MODE_OFFSET);
      chk(v, 32'h00000001);
      $display("backup loss test done");
      complete_run();
   end
endmodule : system_reset_controller_tb

// file: src_pin_partner.sv
// Partner: external device sharing the open-drain reset line with pull-up
`timescale 1ns/1ps
module src_pin_partner (
   input  wire logic ctrl_oe,
   input  wire logic ext_pull,
   output logic      pin_level
);
   // Line is low when either party pulls, pull-up otherwise; any pulse length
   assign pin_level = !(ctrl_oe || ext_pull);
endmodule : src_pin_partner

// file: src_pkg.sv
// Package: register map, field layout and timing counts of the reset controller
package src_pkg;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_OFFSET   = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [7:0] MODE_OFFSET   = 8'h08;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int KEY_LSB          = 24;
   localparam int KEY_W            = 8;
   localparam int CTRL_PROC_BIT    = 0;
   localparam int CTRL_PERIPH_BIT  = 2;
   localparam int CTRL_EXT_BIT     = 3;
   localparam int ST_USTAT_BIT     = 0;
   localparam int ST_TYPE_LSB      = 8;
   localparam int ST_LEVEL_BIT     = 16;
   localparam int ST_BUSY_BIT      = 17;
   localparam int MODE_UEN_BIT     = 0;
   localparam int MODE_IEN_BIT     = 4;
   localparam int MODE_LEN_LSB     = 8;
   localparam int TYPE_W           = 3;
   localparam int LEN_W            = 4;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [LEN_W-1:0] LEN_RESET = 4'h0;
   localparam logic             UEN_RESET = 1'b1;
   localparam logic             IEN_RESET = 1'b0;

   // ---------------------------------------------------------------
   // Reset type codes
   // ---------------------------------------------------------------
   localparam logic [TYPE_W-1:0] TYPE_GENERAL  = 3'h0;
   localparam logic [TYPE_W-1:0] TYPE_WAKEUP   = 3'h1;
   localparam logic [TYPE_W-1:0] TYPE_WATCHDOG = 3'h2;
   localparam logic [TYPE_W-1:0] TYPE_SOFTWARE = 3'h3;
   localparam logic [TYPE_W-1:0] TYPE_USER     = 3'h4;

   // ---------------------------------------------------------------
   // Timing counts in slow clock cycles
   // ---------------------------------------------------------------
   localparam int HOLD_CYCLES     = 3;
   localparam int BOOT_CYCLES     = 3;
   localparam int PIN_MASK_CYCLES = 4;
   localparam int CNT_W           = 17;
   localparam int STARTUP_DEFAULT = 64;

   typedef enum logic [3:0] {
      SRC_BACKUP_OFF, SRC_STARTUP, SRC_CLK_ON, SRC_CORE_OFF, SRC_WAKE,
      SRC_USER, SRC_USER_EXIT, SRC_SOFT, SRC_WDOG, SRC_RUN
   } src_state_t;

endpackage : src_pkg

// file: src_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous inputs
`timescale 1ns/1ps
module src_sync #(
   parameter int         WIDTH    = 1,
   parameter logic [3:0] RST_VAL  = 4'h0
) (
   input  wire logic             clock,
   input  wire logic             rstn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   // ---------------------------------------------------------------
   // Per-bit stages
   // ---------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic s1;
         logic s2;
         logic s3;
         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
               s1          <= RST_VAL[i];
               s2          <= RST_VAL[i];
               s3          <= RST_VAL[i];
               sync_out[i] <= RST_VAL[i];
            end else begin
               s1 <= async_in[i];
               s2 <= s1;
               s3 <= s2;
               // A change counts only once stages two and three agree
               if (s2 == s3) begin
                  sync_out[i] <= s3;
               end
            end
         end
      end
   endgenerate

endmodule : src_sync
